// *** include/lsc_map.vh ***
// Register offsets, field positions, reset values and timing values in ns for the sync control block.
`ifndef LSC_MAP_VH
`define LSC_MAP_VH
`define LSC_OFF_CONTROL 12'h000
`define LSC_OFF_STATUS 12'h004
`define LSC_OFF_MASK 12'h008
`define LSC_OFF_COMPARE 12'h00C
`define LSC_OFF_SYNC_VAL 12'h010
`define LSC_OFF_BRK_VAL 12'h014
`define LSC_OFF_EDGE_CFG 12'h018
`define LSC_CTL_RW_SEL 8
`define LSC_CTL_MODE 6
`define LSC_CTL_CMP_IE 5
`define LSC_CTL_STOP_IE 4
`define LSC_CTL_START_IE 3
`define LSC_CTL_ENABLE 2
`define LSC_CTL_CNT_CLR 1
`define LSC_CTL_RESET 0
`define LSC_ST_BREAK 0
`define LSC_ST_START 1
`define LSC_ST_STOP 2
`define LSC_ST_CMP 3
`define LSC_ST_BRK_ERR 4
`define LSC_CTL_RESET_VAL 16'h0000
`define LSC_BRK_CMP_RESET 12'h047
`define LSC_EDGE_CFG_RESET 8'h32
`define LSC_SELF_CLR_NS 15000
`define LSC_CLK_NS 40
`define LSC_SYNC_TICK_NS 200
`endif

// *** rtl/lsc_tick.v ***
// Tick divider that makes a periodic one-cycle enable from pclk.
`timescale 1ns/10ps
module lsc_tick #(
    parameter DIV = 5
) (
    input wire pclk,
    input wire presetn,
    input wire clr,
    output reg tick
);
    reg [15:0] cnt_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end
        else if (clr)
        begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end
        else if (cnt_q == DIV[15:0] - 16'h0001)
        begin
            cnt_q <= 16'h0000;
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

// *** rtl/lsc_sync_ctrl.v ***
// Single-wire sync unit: control register, timers, edge detection, status and interrupt.
`timescale 1ns/10ps
`include "lsc_map.vh"
module lsc_sync_ctrl #(
    parameter BRK_DIV = 191
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire bus_rx,
    output reg pulse_mode,
    output reg irq
);
    localparam SYNC_DIV = `LSC_SYNC_TICK_NS / `LSC_CLK_NS;
    localparam SELF_CLR_CYC = `LSC_SELF_CLR_NS / `LSC_CLK_NS;
    localparam ST_IDLE = 2'd0;
    localparam ST_RUN = 2'd1;
    localparam ST_DONE = 2'd2;

    reg [15:0] ctl_q;
    reg [4:0] sts_q;
    reg [4:0] mask_q;
    reg [15:0] cmp_q;
    reg [11:0] brk_cmp_q;
    reg [7:0] edge_cfg_q;
    reg [15:0] sync_val_q;
    reg [11:0] brk_val_q;
    reg brk_run_q;
    reg [3:0] fall_cnt_q;
    reg [3:0] edge_cnt_q;
    reg [1:0] st_q;
    reg rx_prev_q;
    reg [9:0] clr_cnt_q;
    reg [9:0] rst_cnt_q;
    reg [7:0] brk_div_q;
    reg cmp_hit_prev_q;

    wire sync_tick;
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    wire unit_rst = ctl_q[`LSC_CTL_RESET];
    wire cnt_clr = ctl_q[`LSC_CTL_CNT_CLR];
    wire en = ctl_q[`LSC_CTL_ENABLE] && !unit_rst;
    wire fall = rx_prev_q && !bus_rx;
    wire rise = !rx_prev_q && bus_rx;
    wire brk_tick = (brk_div_q == BRK_DIV[7:0]);
    wire cmp_hit = (sync_val_q == cmp_q);
    wire addr_ok = (paddr == `LSC_OFF_CONTROL) || (paddr == `LSC_OFF_STATUS) || (paddr == `LSC_OFF_MASK)
        || (paddr == `LSC_OFF_COMPARE) || (paddr == `LSC_OFF_SYNC_VAL) || (paddr == `LSC_OFF_BRK_VAL)
        || (paddr == `LSC_OFF_EDGE_CFG);

    reg [4:0] ev;
    reg start_ev;
    reg stop_ev;

    lsc_tick #(
        .DIV(SYNC_DIV)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .clr(unit_rst),
        .tick(sync_tick)
    );

    always @*
    begin
        start_ev = en && fall && (fall_cnt_q + 4'h1 == edge_cfg_q[3:0]) && (st_q == ST_IDLE);
        stop_ev = 1'b0;
        if (en && st_q == ST_RUN)
        begin
            if (ctl_q[7])
                stop_ev = rise && (edge_cnt_q + 4'h1 == edge_cfg_q[7:4]);
            else
                stop_ev = fall && (fall_cnt_q + 4'h1 == edge_cfg_q[7:4]);
        end
        ev = 5'h00;
        ev[`LSC_ST_START] = start_ev && ctl_q[`LSC_CTL_START_IE];
        ev[`LSC_ST_STOP] = stop_ev && ctl_q[`LSC_CTL_STOP_IE];
        ev[`LSC_ST_CMP] = en && ctl_q[`LSC_CTL_CMP_IE] && cmp_hit && !cmp_hit_prev_q;
        ev[`LSC_ST_BREAK] = en && (ctl_q[`LSC_CTL_MODE] ? (rise && ctl_q[`LSC_CTL_RW_SEL])
            : (brk_run_q && brk_tick && brk_val_q + 12'h001 == brk_cmp_q));
        ev[`LSC_ST_BRK_ERR] = en && brk_run_q && brk_tick && (brk_val_q == 12'hFFF);
    end

    // Control register with the two self-clearing bits.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_q <= `LSC_CTL_RESET_VAL;
            clr_cnt_q <= 10'h000;
            rst_cnt_q <= 10'h000;
        end
        else
        begin
            if (wr && paddr == `LSC_OFF_CONTROL)
                ctl_q <= pwdata[15:0];
            if (ctl_q[`LSC_CTL_CNT_CLR])
            begin
                if (clr_cnt_q == SELF_CLR_CYC[9:0] - 10'h001)
                begin
                    ctl_q[`LSC_CTL_CNT_CLR] <= 1'b0;
                    clr_cnt_q <= 10'h000;
                end
                else
                    clr_cnt_q <= clr_cnt_q + 10'h001;
            end
            if (ctl_q[`LSC_CTL_RESET])
            begin
                if (rst_cnt_q == SELF_CLR_CYC[9:0] - 10'h001)
                begin
                    ctl_q[`LSC_CTL_RESET] <= 1'b0;
                    rst_cnt_q <= 10'h000;
                end
                else
                    rst_cnt_q <= rst_cnt_q + 10'h001;
            end
        end
    end

    // Software-owned settings; unit reset returns all but mask_q to defaults.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_q <= 5'h00;
            cmp_q <= 16'h0000;
            brk_cmp_q <= `LSC_BRK_CMP_RESET;
            edge_cfg_q <= `LSC_EDGE_CFG_RESET;
        end
        else if (unit_rst)
        begin
            cmp_q <= 16'h0000;
            brk_cmp_q <= `LSC_BRK_CMP_RESET;
            edge_cfg_q <= `LSC_EDGE_CFG_RESET;
        end
        else if (wr)
        begin
            case (paddr)
                `LSC_OFF_MASK: mask_q <= pwdata[4:0];
                `LSC_OFF_COMPARE: cmp_q <= pwdata[15:0];
                `LSC_OFF_BRK_VAL: brk_cmp_q <= pwdata[11:0];
                `LSC_OFF_EDGE_CFG: edge_cfg_q <= pwdata[7:0];
                default: mask_q <= mask_q;
            endcase
        end
    end

    // Edge detection, sync timer and edge counters.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_prev_q <= 1'b1;
            sync_val_q <= 16'h0000;
            fall_cnt_q <= 4'h0;
            edge_cnt_q <= 4'h0;
            st_q <= ST_IDLE;
            cmp_hit_prev_q <= 1'b0;
        end
        else
        begin
            rx_prev_q <= bus_rx;
            cmp_hit_prev_q <= cmp_hit && en;
            if (unit_rst || !en)
            begin
                sync_val_q <= 16'h0000;
                fall_cnt_q <= 4'h0;
                edge_cnt_q <= 4'h0;
                st_q <= ST_IDLE;
            end
            else if (cnt_clr)
            begin
                fall_cnt_q <= 4'h0;
                edge_cnt_q <= 4'h0;
                st_q <= ST_IDLE;
            end
            else
            begin
                if (fall)
                    fall_cnt_q <= fall_cnt_q + 4'h1;
                if (rise)
                    edge_cnt_q <= edge_cnt_q + 4'h1;
                case (st_q)
                    ST_IDLE:
                    begin
                        if (start_ev)
                        begin
                            sync_val_q <= 16'h0000;
                            st_q <= ST_RUN;
                        end
                    end
                    ST_RUN:
                    begin
                        if (stop_ev)
                            st_q <= ST_DONE;
                        else if (sync_tick)
                            sync_val_q <= sync_val_q + 16'h0001;
                    end
                    ST_DONE: st_q <= ST_DONE;
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Break timer: cleared by a falling edge or a read, stopped by a rising edge.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            brk_val_q <= 12'h000;
            brk_run_q <= 1'b0;
            brk_div_q <= 8'h00;
        end
        else if (unit_rst || !en)
        begin
            brk_val_q <= 12'h000;
            brk_run_q <= 1'b0;
            brk_div_q <= 8'h00;
        end
        else
        begin
            brk_div_q <= brk_tick ? 8'h00 : brk_div_q + 8'h01;
            if (fall)
            begin
                brk_val_q <= 12'h000;
                brk_run_q <= 1'b1;
            end
            else if (rise)
                brk_run_q <= 1'b0;
            else if (rd && paddr == `LSC_OFF_BRK_VAL)
                brk_val_q <= 12'h000;
            else if (brk_run_q && brk_tick)
            begin
                brk_val_q <= brk_val_q + 12'h001;
                if (brk_val_q == 12'hFFF)
                    brk_run_q <= 1'b0;
            end
        end
    end

    // Sticky status, cleared by reading it. Only the bits that the read returned are cleared, so an event
    // that lands between the setup and access edges is not lost.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sts_q <= 5'h00;
        else if (unit_rst)
            sts_q <= 5'h00;
        else if (rd && paddr == `LSC_OFF_STATUS)
            sts_q <= (sts_q & ~prdata[4:0]) | ev;
        else
            sts_q <= sts_q | ev;
    end

    // APB slave answers in the access cycle; unmapped addresses give pslverr.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pulse_mode <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            pulse_mode <= ctl_q[`LSC_CTL_MODE];
            irq <= |(sts_q & mask_q);
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    `LSC_OFF_CONTROL: prdata <= {16'h0000, ctl_q};
                    `LSC_OFF_STATUS: prdata <= {27'h0, sts_q};
                    `LSC_OFF_MASK: prdata <= {27'h0, mask_q};
                    `LSC_OFF_COMPARE: prdata <= {16'h0000, cmp_q};
                    `LSC_OFF_SYNC_VAL: prdata <= {16'h0000, sync_val_q};
                    `LSC_OFF_BRK_VAL: prdata <= {20'h00000, brk_val_q};
                    `LSC_OFF_EDGE_CFG: prdata <= {24'h000000, edge_cfg_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// *** test/lsc_bus_node.sv ***
// Bus node model driving the single-wire bus level.
`timescale 1ns/10ps
module lsc_bus_node (
    input wire logic pclk,
    output logic bus_rx
);
    // The wire has a pull-up, so a released bus reads high.
    initial bus_rx = 1'b1;
    task automatic pulse(input int n);
        bus_rx <= 1'b0;
        repeat (n) @(posedge pclk);
        bus_rx <= 1'b1;
        // Stay released long enough that a later mode switch sees an idle pin.
        repeat (n) @(posedge pclk);
    endtask
endmodule

// *** test/lsc_sync_ctrl_assertions.sv ***
// Concurrent checks on the ports of the sync control block.
`timescale 1ns/10ps
module lsc_sync_ctrl_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire bus_rx,
    input wire pulse_mode,
    input wire irq
);
    reg [8:0] sc_q;
    reg mz_q;
    wire acc = psel && penable;
    wire wr_ctl = acc && pwrite && paddr == 12'h000;
    wire rd_ctl = acc && !pwrite && pready && paddr == 12'h000;
    // Age of the last write that set both self-clearing bits; saturates.
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            sc_q <= 9'h1FF;
            mz_q <= 1'b1;
        end
        else
        begin
            if (wr_ctl && pwdata[1:0] == 2'h3)
                sc_q <= 9'h000;
            else if (sc_q != 9'h1FF)
                sc_q <= sc_q + 9'h001;
            if (acc && pwrite && paddr == 12'h008)
                mz_q <= pwdata[4:0] == 5'h00;
        end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PULSE_MODE: assert property (wr_ctl |-> ##2 pulse_mode == $past(pwdata[6], 2))
        else $error("pulse_mode does not follow control bit 6");
    AST_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer in access phase");
    AST_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused access returns data");
    AST_UPPER_ZERO: assert property (rd_ctl |-> prdata[31:16] == 16'h0000)
        else $error("control upper bits not zero");
    AST_CLR_HELD: assert property (rd_ctl && sc_q < 9'h168 |-> prdata[1])
        else $error("counter clear bit dropped early");
    AST_CLR_DONE: assert property (rd_ctl && sc_q > 9'h186 |-> !prdata[1])
        else $error("counter clear bit not self-cleared");
    AST_RST_HELD: assert property (rd_ctl && sc_q < 9'h168 |-> prdata[0])
        else $error("unit reset bit dropped early");
    AST_RST_DONE: assert property (rd_ctl && sc_q > 9'h186 |-> !prdata[0])
        else $error("unit reset bit not self-cleared");
    AST_IRQ_MASKED: assert property (mz_q && $past(mz_q) |-> !irq)
        else $error("irq with all sources masked");
endmodule
bind lsc_sync_ctrl lsc_sync_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_rx(bus_rx), .pulse_mode(pulse_mode), .irq(irq));

// *** test/lin_sync_control_bits_tb.sv ***
// Self-checking bench for the sync control block over APB.
`timescale 1ns/10ps
module lin_sync_control_bits_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire bus_rx;
    wire pulse_mode;
    wire irq;
    logic [31:0] rd;
    logic [31:0] rnd;
    logic [4:0] ex;
    logic err;
    int mismatches = 0;
    int cmp_count = 0;
    integer seed = 86;
    logic [15:0] r_ctl [7] = '{16'h0064, 16'h0044, 16'h0060, 16'h0144, 16'h0064, 16'h0024, 16'h009C};
    logic [4:0] r_msk [7] = '{5'h08, 5'h08, 5'h08, 5'h01, 5'h00, 5'h09, 5'h06};
    lsc_sync_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_rx(bus_rx), .pulse_mode(pulse_mode), .irq(irq));
    lsc_bus_node u_node (.pclk(pclk), .bus_rx(bus_rx));
    always #20 pclk = ~pclk;
    // Status bits {error, compare, stop, start, break} that two long low pulses should leave behind,
    // with break compare 1 and edge config 0x22 (start on 2nd fall, rising stop on 2nd rise).
    function automatic logic [4:0] exp_st(input logic [15:0] c);
        exp_st = {1'b0, c[2] & c[5], c[2] & c[4] & c[7], c[2] & c[3], c[2] & (c[6] ? c[8] : 1'b1)};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            mismatches++;
            wrap_up();
        end
        // An idle edge keeps back-to-back calls from assigning psel twice in one step.
        @(posedge pclk);
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, 12'h018, 32'h0);
        chk("edge cfg reset", 32'h32, rd);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        $display("test reset values done");
        apb(1'b1, 12'h000, 32'h3);
        repeat (10) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk("self clear held", 32'h3, rd);
        chk("lin mode", 32'h0, {31'h0, pulse_mode});
        repeat (400) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk("self clear done", 32'h0, rd);
        $display("test self clear done");
        apb(1'b1, 12'h018, 32'h22);
        apb(1'b1, 12'h014, 32'h1);
        for (int i = 0; i < 7; i++)
        begin
            rnd = $random(seed);
            // Disabling first keeps edge counts and timer state of the previous row from carrying over.
            apb(1'b1, 12'h000, 32'h0);
            apb(1'b1, 12'h008, {27'h0, r_msk[i]});
            apb(1'b1, 12'h00C, {28'h0, rnd[3:0]} + 32'h4);
            apb(1'b1, 12'h000, {16'h0, r_ctl[i]});
            @(posedge pclk);
            chk("pulse mode", {31'h0, r_ctl[i][6]}, {31'h0, pulse_mode});
            apb(1'b0, 12'h004, 32'h0);
            u_node.pulse(200);
            u_node.pulse(200);
            repeat (4) @(posedge pclk);
            ex = exp_st(r_ctl[i]);
            chk("irq raised", {31'h0, |(ex & r_msk[i])}, {31'h0, irq});
            apb(1'b0, 12'h004, 32'h0);
            chk("status", {27'h0, ex}, rd);
            if (r_ctl[i][7])
            begin
                // The timer runs from the 2nd fall to the 2nd rise, 200 cycles of 5-cycle ticks.
                apb(1'b0, 12'h010, 32'h0);
                chk("sync timer", 32'h1, {31'h0, rd == 32'h27 || rd == 32'h28});
            end
            repeat (2) @(posedge pclk);
            chk("irq cleared", 32'h0, {31'h0, irq});
            $display("test row %0d done", i);
        end
        wrap_up();
    end
endmodule
